// [hdl/ssel_pkg.sv]
/*
  Constants shared by the sensor supervisor: register map, status bit positions,
  reset values and timing counts derived from the 40 MHz system clock.
  Assumes a single clock domain at CLOCK_HZ.
*/
package ssel_pkg;
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;

  // status / mask bit positions
  localparam int EV_BROWNOUT = 0;
  localparam int EV_EXT_RESET = 1;
  localparam int EV_OVERLOAD = 2;
  localparam int EV_STARTED = 3;
  localparam int EV_W = 4;

  // state register layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_POWER_GOOD = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_AUTOCHECK = 4;

  // control register layout
  localparam int CTRL_AUTOCHECK = 0;

  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // startup delay after power good: 40 us
  localparam int unsigned STARTUP_US = 40;
  localparam int unsigned STARTUP_CYCLES = STARTUP_US * (CLOCK_HZ / 1_000_000);
  localparam int STARTUP_W = 11;

  // switched-capacitor clock: 200 kHz, toggled every half period
  localparam int unsigned SC_CLOCK_HZ = 200_000;
  localparam int unsigned SC_HALF_CYCLES = CLOCK_HZ / (2 * SC_CLOCK_HZ);
  localparam int SC_W = 7;

  // self-test square wave: 24.4 Hz, kept in centi-hertz
  localparam longint unsigned AUTOCHECK_CHZ = 2440;
  localparam longint unsigned AUTOCHECK_HALF_CYCLES =
    (64'(CLOCK_HZ) * 64'd100) / (64'd2 * AUTOCHECK_CHZ);
  localparam int AUTOCHECK_W = 20;

  typedef enum logic [1:0] {
    ssel_off = 2'b00,
    ssel_startup = 2'b01,
    ssel_run = 2'b10
  } ssel_state_type;
endpackage

// [hdl/ssel_top.sv]
/*
  Supervisory logic of a single-axis sensor: power supervision, external reset,
  self-test square wave, fault flag, overload restart and a small register port
  with a sticky event status and one interrupt line.
  Assumes supply_ok and overload_detect come from synchronous comparators;
  reset_in_n and autocheck_enable are pins and are synchronised here.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
// Contract
// R1: at power on, power good stays low until the supply passes the threshold, then startup begins.
// R2: a supply drop forces power good low until it recovers, followed by a fresh startup.
// R3: the fault flag is high from power on until startup has completed.
// R4: the reset pin is active low with a pull-up, so an open pin means no reset.
// R5: while external reset is held, both outputs go to mid supply and the fault flag is high.
// R6: the self-test pin is active high with a pull-down, so an open pin means no self-test.
// R7: while self-test is on, a square wave of about 24 Hz and 1.3 g rides on the outputs.
// R8: the host should run self-test only with the sensor at rest.
// R9: the fault flag is high whenever the outputs are invalid: supply bad, reset, or overload.
// R10: an overload resets the readout and restarts startup until acceleration is back in range.
// R11: the sensor becomes operational about 40 us after power good rises.
// R12: the readout electronics run from a 200 kHz switched-capacitor clock.
// R13: reset and self-test pins are synchronised before they are acted on.
// R14: the fault flag clears only after the startup that follows an overload or reset ends.
`timescale 1ns/1ps
module ssel_top #(
  parameter int unsigned AUTOCHECK_HALF = 32'(ssel_pkg::AUTOCHECK_HALF_CYCLES)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic supply_ok,
  input wire logic reset_in_n,
  input wire logic autocheck_enable,
  input wire logic overload_detect,
  input wire logic [ssel_pkg::ADDR_W-1:0] address,
  input wire logic [ssel_pkg::DATA_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [ssel_pkg::DATA_W-1:0] read_data,
  output logic power_good,
  output logic fault_flag,
  output logic readout_reset,
  output logic outputs_to_mid,
  output logic stimulus_on,
  output logic stimulus_phase,
  output logic sc_clock,
  output logic irq
);
  import ssel_pkg::*;

  logic [1:0] sync_stage [2];
  logic ext_active;
  logic autocheck_pin;
  logic autocheck_active;
  ssel_state_type state;
  ssel_state_type next_state;
  logic [STARTUP_W-1:0] startup_count;
  logic [STARTUP_W-1:0] next_startup_count;
  logic [SC_W-1:0] sc_count;
  logic [AUTOCHECK_W-1:0] wave_count;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic ctrl_autocheck;
  logic ext_prev;
  logic overload_prev;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clear_bits;

  // two-flop synchronisers, bit 0 = reset pin, bit 1 = self-test pin
  // presets match the idle pin levels, so leaving reset shows no false edge
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (reset) begin
          sync_stage[gi] <= (gi == 0) ? 2'b11 : 2'b00;
        end else begin
          sync_stage[gi] <= {sync_stage[gi][0], (gi == 0) ? reset_in_n : autocheck_enable}; // [R13]
        end
      end
    end
  endgenerate

  assign ext_active = !sync_stage[0][1]; // [R4]
  assign autocheck_pin = sync_stage[1][1]; // [R6]
  assign autocheck_active = autocheck_pin | ctrl_autocheck;

  // overload and external reset keep the sequencer parked at count zero
  // in run the count stays put; only a cause from outside sends it back to zero
  always_comb begin
    next_state = state;
    next_startup_count = startup_count;
    if (!supply_ok) begin
      next_state = ssel_off; // [R1] [R2]
      next_startup_count = '0;
    end else if (ext_active || overload_detect) begin
      next_state = ssel_startup; // [R10]
      next_startup_count = '0;
    end else begin
      unique case (state)
        ssel_off: begin
          next_state = ssel_startup; // [R1]
          next_startup_count = '0;
        end
        ssel_startup: begin
          if (startup_count == STARTUP_W'(STARTUP_CYCLES - 1)) begin
            next_state = ssel_run; // [R11]
          end else begin
            next_startup_count = startup_count + 1'b1;
          end
        end
        ssel_run: begin
          next_state = ssel_run;
        end
        default: begin
          next_state = ssel_off;
          next_startup_count = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ssel_off;
      startup_count <= '0;
    end else begin
      state <= next_state;
      startup_count <= next_startup_count;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      power_good <= 1'b0;
      fault_flag <= 1'b1;
      readout_reset <= 1'b1;
      outputs_to_mid <= 1'b0;
    end else begin
      power_good <= supply_ok; // [R1] [R2]
      // released only by completion of startup, never by the cause going away
      fault_flag <= (next_state != ssel_run); // [R3] [R9] [R14]
      // a held overload keeps the count at zero, so the readout stays in reset
      readout_reset <= (next_state != ssel_run) && (next_startup_count == '0); // [R10]
      outputs_to_mid <= ext_active; // [R5]
    end
  end

  // 200 kHz switched-capacitor clock
  // free running: the readout clock does not stop during startup or external reset
  always_ff @(posedge clock) begin
    if (reset) begin
      sc_count <= '0;
      sc_clock <= 1'b0;
    end else if (sc_count == SC_W'(SC_HALF_CYCLES - 1)) begin
      sc_count <= '0;
      sc_clock <= !sc_clock; // [R12]
    end else begin
      sc_count <= sc_count + 1'b1;
    end
  end

  // self-test square wave, 50 % duty; only shown once the outputs are valid
  always_ff @(posedge clock) begin
    if (reset) begin
      wave_count <= '0;
      stimulus_phase <= 1'b0;
      stimulus_on <= 1'b0;
    end else begin
      stimulus_on <= autocheck_active && (next_state == ssel_run); // [R7]
      if (!autocheck_active) begin
        wave_count <= '0;
        stimulus_phase <= 1'b0;
      end else if (wave_count == AUTOCHECK_W'(AUTOCHECK_HALF - 1)) begin
        wave_count <= '0;
        stimulus_phase <= !stimulus_phase; // [R7]
      end else begin
        wave_count <= wave_count + 1'b1;
      end
    end
  end

  // event capture for the sticky status register
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_prev <= 1'b0;
      overload_prev <= 1'b0;
    end else begin
      ext_prev <= ext_active;
      overload_prev <= overload_detect;
    end
  end

  always_comb begin
    events = '0;
    events[EV_BROWNOUT] = power_good && !supply_ok;
    events[EV_EXT_RESET] = ext_active && !ext_prev;
    events[EV_OVERLOAD] = overload_detect && !overload_prev;
    events[EV_STARTED] = (state == ssel_startup) && (next_state == ssel_run);
    clear_bits = '0;
    if (write_strobe && address == ADDR_STATUS) begin
      clear_bits = write_data[EV_W-1:0];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= (status & ~clear_bits) | events;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mask <= MASK_RESET;
      ctrl_autocheck <= 1'b0;
    end else if (write_strobe) begin
      if (address == ADDR_MASK) begin
        mask <= write_data[EV_W-1:0];
      end
      if (address == ADDR_CONTROL) begin
        ctrl_autocheck <= write_data[CTRL_AUTOCHECK];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= ZERO_WORD;
    end else begin
      read_data <= ZERO_WORD;
      // zero outside the read cycle, so a stale word never looks like fresh data
      if (read_strobe) begin
        unique case (address)
          ADDR_STATUS: read_data[EV_W-1:0] <= status;
          ADDR_MASK: read_data[EV_W-1:0] <= mask;
          ADDR_STATE: begin
            read_data[ST_STATE_LSB +: 2] <= state;
            read_data[ST_POWER_GOOD] <= power_good;
            read_data[ST_FAULT] <= fault_flag;
            read_data[ST_AUTOCHECK] <= autocheck_active;
          end
          ADDR_CONTROL: read_data[CTRL_AUTOCHECK] <= ctrl_autocheck;
          default: read_data <= ZERO_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      // one cycle behind the status so the pin comes straight from a flop
      irq <= |(status & mask);
    end
  end

  // every check runs on the one system clock and sleeps through reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_power_good_drop: assert property (!supply_ok |=> !power_good && fault_flag) // [R1] [R2]
    else $error("power good or fault wrong after supply drop");
  a_fault_until_run: assert property (state != ssel_run |-> fault_flag) // [R3]
    else $error("fault flag low before startup completed");
  a_reset_to_mid: assert property (!reset_in_n |-> ##3 (outputs_to_mid && fault_flag)) // [R5] [R13]
    else $error("external reset did not force mid outputs and fault");
  a_overload_fault: assert property (overload_detect && supply_ok |=> fault_flag && readout_reset) // [R9] [R10]
    else $error("overload did not raise fault and restart readout");
  a_startup_length: assert property ($rose(state == ssel_run) |->
    $past(startup_count) == STARTUP_W'(STARTUP_CYCLES - 1)) // [R11]
    else $error("startup delay length wrong");
  a_fault_after_cause: assert property ($fell(ext_active) && supply_ok && !overload_detect
    |=> fault_flag [*8]) // [R14]
    else $error("fault released before startup ended");
  a_sc_half_period: assert property ($changed(sc_clock) |=> $stable(sc_clock) [*8]) // [R12]
    else $error("switched-capacitor clock toggled too soon");
  a_stim_gated: assert property (!autocheck_active || next_state != ssel_run
    |=> !stimulus_on) // [R7]
    else $error("stimulus present without self-test in run");
  a_irq_level: assert property (|(status & mask) |=> irq)
    else $error("interrupt missing for unmasked status");
  a_mid_release: assert property (reset_in_n |-> ##3 !outputs_to_mid) // [R5] [R13]
    else $error("mid outputs held without external reset");
  a_pg_follows: assert property (supply_ok |=> power_good) // [R1]
    else $error("power good missing with supply in range");
  a_run_needs_supply: assert property (state == ssel_run |-> power_good) // [R2]
    else $error("sequencer running without power good");
  a_overload_hold: assert property (overload_detect && supply_ok |=> // [R10]
    state == ssel_startup && startup_count == '0)
    else $error("overload did not park the startup count");
  a_phase_idle: assert property (!autocheck_active |=> !stimulus_phase) // [R7]
    else $error("square wave running without self-test");
  a_status_sticky: assert property (!(write_strobe && address == ADDR_STATUS)
    |=> (status & $past(status)) == $past(status))
    else $error("status bit lost without a clear");

  c_reach_run: cover property (state == ssel_startup ##1 state == ssel_run);
  c_overload_restart: cover property (state == ssel_run ##1 overload_detect ##1 readout_reset);
  c_self_test_toggle: cover property (stimulus_on && $changed(stimulus_phase));
  c_brownout: cover property (power_good ##1 !power_good);
  c_external_reset: cover property ($rose(outputs_to_mid));
endmodule

// [sim/ssel_host.sv]
/*
  Host model: drives the sensor reset and self-test pins.
  Assumes the host shares the sensor's clock.
*/
`timescale 1ns/1ps
module ssel_host (
  input wire logic clock,
  input wire logic want_reset,
  input wire logic want_check,
  input wire logic overload_detect,
  output logic reset_in_n,
  output logic autocheck_enable
);
  initial begin
    reset_in_n = 1'b1;
    autocheck_enable = 1'b0;
    forever begin
      @(posedge clock);
      reset_in_n <= !want_reset;
      // never start self-test while the sensor is shaken
      autocheck_enable <= want_check && !overload_detect;
    end
  end
endmodule

// [sim/ssel_top_bench.sv]
/*
  Self-checking bench of the sensor supervisor.
  Assumes ssel_top and ssel_host; self-test half period shortened to 8.
*/
`timescale 1ns/1ps
module ssel_top_bench;
  import ssel_pkg::*;
  localparam int LO = STARTUP_CYCLES - 1;
  localparam int HI = STARTUP_CYCLES + 6;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic supply_ok = 1'b0;
  logic overload_detect = 1'b0;
  logic want_reset = 1'b0;
  logic want_check = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] write_data = 32'h0000_0000;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [31:0] read_data, word, got;
  logic reset_in_n, autocheck_enable, power_good, fault_flag, readout_reset;
  logic outputs_to_mid, stimulus_on, stimulus_phase, sc_clock, irq;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h0000_a031;
  int n, exp_status;

  ssel_top #(.AUTOCHECK_HALF(8)) dut (.clock(clock), .reset(reset), .supply_ok(supply_ok),
    .reset_in_n(reset_in_n), .autocheck_enable(autocheck_enable),
    .overload_detect(overload_detect), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .power_good(power_good), .fault_flag(fault_flag), .readout_reset(readout_reset),
    .outputs_to_mid(outputs_to_mid), .stimulus_on(stimulus_on),
    .stimulus_phase(stimulus_phase), .sc_clock(sc_clock), .irq(irq));
  ssel_host host (.clock(clock), .want_reset(want_reset), .want_check(want_check),
    .overload_detect(overload_detect), .reset_in_n(reset_in_n),
    .autocheck_enable(autocheck_enable));

  initial forever #12.5 clock = ~clock;

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      close_out;
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask

  task automatic chk_in(input string what, input int g);
    n_checks++;
    if (g < LO || g > HI) begin
      failures++;
      $display("BAD %s expected %0d..%0d seen %0d", what, LO, HI, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // a spare cycle after each access keeps a strobe from being set twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    tick(1);
    write_strobe <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    address <= a;
    read_strobe <= 1'b1;
    tick(1);
    d = read_data;
    read_strobe <= 1'b0;
    tick(1);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return sc_clock;
      1: return stimulus_phase;
      2: return outputs_to_mid;
      default: return fault_flag;
    endcase
  endfunction

  task automatic gap(input int s, output int k);
    logic v;
    v = pick(s);
    k = 0;
    while (pick(s) === v && k < 3000) begin
      tick(1);
      k++;
    end
  endtask

  task automatic status_is(input int e);
    rd(ADDR_STATUS, word);
    chk("status", 32'(e), word);
    wr(ADDR_STATUS, 32'h0000_000f);
  endtask

  initial begin
    tick(12);
    reset <= 1'b0;
    tick(1);
    chk("power_good", 1'b0, power_good);
    chk("fault_flag", 1'b1, fault_flag);
    chk("readout_reset", 1'b1, readout_reset);
    rd(ADDR_MASK, word);
    chk("mask", 32'(MASK_RESET), word);
    supply_ok <= 1'b1;
    tick(2);
    chk("power_good", 1'b1, power_good);
    gap(3, n);
    chk_in("startup", n + 2);
    rd(ADDR_STATE, word);
    chk("state", 32'(ssel_run) | (32'h0000_0001 << ST_POWER_GOOD), word);
    gap(0, n);
    gap(0, n);
    chk("sc_half", SC_HALF_CYCLES, 32'(n));
    wr(ADDR_MASK, 32'h0000_0008);
    chk("irq", 1'b1, irq);
    wr(ADDR_MASK, 32'h0000_0000);
    chk("irq", 1'b0, irq);
    word = $random(seed);
    wr(ADDR_MASK, word);
    rd(ADDR_MASK, got);
    chk("mask", word & 32'h0000_000f, got);
    status_is(8);
    rd(8'h40, word);
    chk("unmapped", 32'h0000_0000, word);
    wr(ADDR_MASK, 32'h0000_0002);
    want_reset <= 1'b1;
    gap(2, n);
    chk("to_mid delay", 32'h0000_0004, 32'(n));
    tick(2);
    chk("fault_flag", 1'b1, fault_flag);
    chk("irq", 1'b1, irq);
    tick(20);
    want_reset <= 1'b0;
    gap(3, n);
    chk_in("reset restart", n);
    chk("outputs_to_mid", 1'b0, outputs_to_mid);
    status_is(10);
    want_check <= 1'b1;
    tick(5);
    chk("stimulus_on", 1'b1, stimulus_on);
    gap(1, n);
    gap(1, n);
    chk("phase half", 32'h0000_0008, 32'(n));
    rd(ADDR_STATE, word);
    chk("autocheck", 1'b1, word[ST_AUTOCHECK]);
    want_check <= 1'b0;
    tick(5);
    chk("stimulus_on", 1'b0, stimulus_on);
    wr(ADDR_CONTROL, 32'h0000_0001);
    tick(1);
    chk("stimulus_on", 1'b1, stimulus_on);
    wr(ADDR_CONTROL, 32'h0000_0000);
    overload_detect <= 1'b1;
    tick(2);
    chk("fault_flag", 1'b1, fault_flag);
    tick(1 + ($random(seed) & 7));
    chk("readout_reset", 1'b1, readout_reset);
    overload_detect <= 1'b0;
    gap(3, n);
    chk_in("overload restart", n);
    chk("readout_reset", 1'b0, readout_reset);
    status_is(12);
    supply_ok <= 1'b0;
    tick(2);
    chk("power_good", 1'b0, power_good);
    chk("fault_flag", 1'b1, fault_flag);
    tick(5);
    supply_ok <= 1'b1;
    tick(2);
    gap(3, n);
    chk_in("brownout restart", n + 2);
    exp_status = 9;
    status_is(exp_status);
    close_out;
  end
endmodule
